// ### shared/rdp_consts.svh
// Offsets, field positions, reset values and widths for the receive list pointer block
`ifndef RDP_CONSTS_SVH
`define RDP_CONSTS_SVH

// ****************************************
// Widths
// ****************************************
`define RDP_AW           8
`define RDP_DW           32

// ****************************************
// Device register map
// ****************************************
`define RDP_REG_CMD      8'h00
`define RDP_REG_STAT     8'h04
`define RDP_REG_PTR      8'h30
`define RDP_PTR_RST      32'h0000_0000
`define RDP_CMD_GO       0
`define RDP_CMD_STOP     1
`define RDP_STAT_ACTIVE  3
`define RDP_STAT_SILENT  4
`define RDP_STAT_LEND    5
`define RDP_LINK_OFS     32'h0000_0000

// ****************************************
// Host register map
// ****************************************
`define RDP_H_STAGE      8'h00
`define RDP_H_CTRL       8'h04
`define RDP_H_STAT       8'h08
`define RDP_H_MIRROR     8'h0c
`define RDP_HC_ARM       0
`define RDP_HC_SILENT    1
`define RDP_HC_STOP      2
`define RDP_HC_SAMPLE    3
`define RDP_HS_BUSY      0
`define RDP_HS_DEVBUSY   1
`define RDP_HS_ERR       2

`endif

// ### shared/rdp_pkg.sv
// Types shared by both ends of the receive list pointer block
package rdp_pkg;

  // Device receive sequencer, Gray along idle-ready-move-fetch-end
  typedef enum logic [2:0] {
    RDP_IDLE   = 3'h0,
    RDP_READY  = 3'h1,
    RDP_MOVE   = 3'h3,
    RDP_FETCH  = 3'h2,
    RDP_LEND   = 3'h6,
    RDP_SILENT = 3'h4
  } rdp_dev_state_t;

  // Host command sequencer
  typedef enum logic [1:0] {
    RDP_H_IDLE = 2'h0,
    RDP_H_GO   = 2'h1,
    RDP_H_RDC  = 2'h3,
    RDP_H_RDW  = 2'h2
  } rdp_host_state_t;

endpackage

// ### shared/rdp_if.sv
// Link between the host end and the device end of the receive list pointer block
`timescale 1ns/1ps
`include "rdp_consts.svh"
interface rdp_if;
  logic                reg_wr;
  logic                reg_rd;
  logic [`RDP_AW-1:0]  reg_addr;
  logic [`RDP_DW-1:0]  reg_wdata;
  logic [`RDP_DW-1:0]  reg_rdata;
  logic                rx_busy;
  logic                mem_req;
  logic [`RDP_DW-1:0]  mem_addr;
  logic                mem_ack;
  logic [`RDP_DW-1:0]  mem_rdata;

  modport dev (
    input  reg_wr, reg_rd, reg_addr, reg_wdata, mem_ack, mem_rdata,
    output reg_rdata, rx_busy, mem_req, mem_addr
  );
  modport host (
    output reg_wr, reg_rd, reg_addr, reg_wdata, mem_ack, mem_rdata,
    input  reg_rdata, rx_busy, mem_req, mem_addr
  );
endinterface

// ### hw/rdp_ptr_reg.sv
// Word-aligned receive list pointer register
`timescale 1ns/1ps
`include "rdp_consts.svh"
module rdp_ptr_reg
  import rdp_pkg::*;
(
  // Clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  // Software write
  input  wire logic               i_wr,
  input  wire logic [`RDP_DW-1:0] i_wdata,
  // Hardware advance
  input  wire logic               i_load,
  input  wire logic [`RDP_DW-1:0] i_link,
  // Pointer
  output logic      [`RDP_DW-1:0] o_ptr
);

  logic [`RDP_DW-3:0] ptr_q;
  localparam logic [`RDP_DW-1:0] PTR_RST = `RDP_PTR_RST;

  // Low two bits are never stored, so every fetch stays word aligned
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_q <= PTR_RST[`RDP_DW-1:2];
    end else if (i_wr) begin
      ptr_q <= i_wdata[`RDP_DW-1:2];
    end else if (i_load) begin
      ptr_q <= i_link[`RDP_DW-1:2];
    end
  end

  assign o_ptr = {ptr_q, 2'b00};

endmodule // rdp_ptr_reg

// ### hw/rdp_dev.sv
// Device end: receive list pointer, link walk and silent receive mode
`timescale 1ns/1ps
`include "rdp_consts.svh"

// ****************************************
// Receive list pointer sequencer
// ****************************************

// Summary of operation
// - Software loads pointer while idle, before go
// - Pointer follows sequencer through linked descriptors
// - Null link keeps pointer on current descriptor
// - Go strobe at list end rereads current link field
// - Software writes pointer only while not receiving: idle, silent or list end
// - Software writes word-aligned pointers only
// - Zero pointer then go enters silent mode, except at list end where go refetches the link
// - Silent mode buffers frames, moves nothing
// - Valid pointer then go drains buffered frames
module rdp_dev
  import rdp_pkg::*;
(
  // Clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  // Link to host end
  rdp_if.dev                      bus,
  // Receive FIFO side
  input  wire logic               i_frame_rdy,
  input  wire logic               i_dma_done,
  output logic                    o_dma_go,
  output logic      [`RDP_DW-1:0] o_dma_desc,
  // Status
  output logic                    o_rx_active,
  output logic                    o_silent,
  output logic                    o_list_end
);

  // ****************************************
  // Register decode
  // ****************************************
  logic               go_s;
  logic               stop_s;
  logic               ptr_wr;
  logic [`RDP_DW-1:0] ptr;
  logic               ptr_null;
  logic               link_null;
  logic               link_load;

  assign go_s   = bus.reg_wr && (bus.reg_addr == `RDP_REG_CMD)
                  && bus.reg_wdata[`RDP_CMD_GO];
  assign stop_s = bus.reg_wr && (bus.reg_addr == `RDP_REG_CMD)
                  && bus.reg_wdata[`RDP_CMD_STOP];
  // Accepted at any time; keeping writes to idle periods is software's job
  assign ptr_wr = bus.reg_wr && (bus.reg_addr == `RDP_REG_PTR);

  assign ptr_null  = (ptr[`RDP_DW-1:2] == '0);
  assign link_null = (bus.mem_rdata[`RDP_DW-1:2] == '0);

  // ****************************************
  // Sequencer
  // ****************************************
  rdp_dev_state_t state_q;
  rdp_dev_state_t state_d;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      RDP_IDLE: begin
        if (go_s && !stop_s) begin
          // Pointer was loaded while idle
          state_d = ptr_null ? RDP_SILENT : RDP_READY;
        end
      end
      RDP_SILENT: begin
        if (stop_s) begin
          state_d = RDP_IDLE;
        end else if (go_s && !ptr_null) begin
          state_d = RDP_READY;
        end
      end
      RDP_READY: begin
        if (stop_s) begin
          state_d = RDP_IDLE;
        end else if (i_frame_rdy) begin
          state_d = RDP_MOVE;
        end
      end
      RDP_MOVE: begin
        // A started transfer always completes; stop is refused here
        if (i_dma_done) begin
          state_d = RDP_FETCH;
        end
      end
      RDP_FETCH: begin
        if (bus.mem_ack) begin
          state_d = link_null ? RDP_LEND : RDP_READY;
        end
      end
      RDP_LEND: begin
        if (stop_s) begin
          state_d = RDP_IDLE;
        end else if (go_s) begin
          state_d = RDP_FETCH;
        end
      end
      default: begin
        state_d = RDP_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= RDP_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ****************************************
  // Pointer
  // ****************************************
  // Null link leaves the pointer where it is
  assign link_load = (state_q == RDP_FETCH) && bus.mem_ack && !link_null;

  rdp_ptr_reg u_ptr (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_wr    (ptr_wr),
    .i_wdata (bus.reg_wdata),
    .i_load  (link_load),
    .i_link  (bus.mem_rdata),
    .o_ptr   (ptr)
  );

  // ****************************************
  // Link fetch request
  // ****************************************
  logic               mem_req_q;
  logic [`RDP_DW-1:0] mem_addr_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_req_q  <= 1'b0;
      mem_addr_q <= '0;
    end else begin
      // One pulse on every entry to the fetch state
      mem_req_q <= (state_d == RDP_FETCH) && (state_q != RDP_FETCH);
      if ((state_d == RDP_FETCH) && (state_q != RDP_FETCH)) begin
        mem_addr_q <= ptr + `RDP_LINK_OFS;
      end
    end
  end

  assign bus.mem_req  = mem_req_q;
  assign bus.mem_addr = mem_addr_q;

  // ****************************************
  // Transfer start
  // ****************************************
  logic               dma_go_q;
  logic [`RDP_DW-1:0] dma_desc_q;

  // No path from silent to move, so nothing reaches memory there
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      dma_go_q   <= 1'b0;
      dma_desc_q <= '0;
    end else begin
      dma_go_q <= (state_q == RDP_READY) && (state_d == RDP_MOVE);
      if ((state_q == RDP_READY) && (state_d == RDP_MOVE)) begin
        dma_desc_q <= ptr;
      end
    end
  end

  assign o_dma_go   = dma_go_q;
  assign o_dma_desc = dma_desc_q;

  // ****************************************
  // Status
  // ****************************************
  logic active_q;
  logic silent_q;
  logic lend_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      active_q <= 1'b0;
      silent_q <= 1'b0;
      lend_q   <= 1'b0;
    end else begin
      active_q <= (state_d == RDP_READY) || (state_d == RDP_MOVE)
                  || (state_d == RDP_FETCH);
      silent_q <= (state_d == RDP_SILENT);
      lend_q   <= (state_d == RDP_LEND);
    end
  end

  assign o_rx_active = active_q;
  assign o_silent    = silent_q;
  assign o_list_end  = lend_q;
  assign bus.rx_busy = active_q;

  // ****************************************
  // Register read
  // ****************************************
  logic [`RDP_DW-1:0] rdata_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rdata_q <= '0;
    end else if (bus.reg_rd) begin
      unique case (bus.reg_addr)
        `RDP_REG_PTR: begin
          rdata_q <= ptr;
        end
        `RDP_REG_STAT: begin
          rdata_q <= {26'h0, lend_q, silent_q, active_q, state_q};
        end
        default: begin
          rdata_q <= '0;
        end
      endcase
    end
  end

  assign bus.reg_rdata = rdata_q;

endmodule // rdp_dev

// ### hw/rdp_host.sv
// Host end: software command port driving the device registers, memory link forwarding
`timescale 1ns/1ps
`include "rdp_consts.svh"
module rdp_host
  import rdp_pkg::*;
(
  // Clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_rst_n,
  // Software port
  input  wire logic [`RDP_AW-1:0] i_sw_addr,
  input  wire logic [`RDP_DW-1:0] i_sw_wdata,
  input  wire logic               i_sw_wr,
  input  wire logic               i_sw_rd,
  output logic      [`RDP_DW-1:0] o_sw_rdata,
  // System memory
  output logic                    o_mem_req,
  output logic      [`RDP_DW-1:0] o_mem_addr,
  input  wire logic               i_mem_ack,
  input  wire logic [`RDP_DW-1:0] i_mem_rdata,
  // Link to device end
  rdp_if.host                     bus
);

  // ****************************************
  // Software registers
  // ****************************************
  logic [`RDP_DW-1:0] stage_q;
  logic [`RDP_DW-1:0] mirror_q;
  logic               err_q;
  logic               ctrl_wr;
  logic               arm_s;
  logic               silent_s;
  logic               stop_s;
  logic               sample_s;
  logic               refuse_s;
  rdp_host_state_t    state_q;

  assign ctrl_wr  = i_sw_wr && (i_sw_addr == `RDP_H_CTRL) && (state_q == RDP_H_IDLE);
  assign stop_s   = ctrl_wr && i_sw_wdata[`RDP_HC_STOP];
  assign arm_s    = ctrl_wr && !stop_s && i_sw_wdata[`RDP_HC_ARM];
  assign silent_s = ctrl_wr && !stop_s && !arm_s && i_sw_wdata[`RDP_HC_SILENT];
  assign sample_s = ctrl_wr && !stop_s && !arm_s && !silent_s
                    && i_sw_wdata[`RDP_HC_SAMPLE];
  // Pointer only goes out while the device is not receiving (rx_busy low)
  assign refuse_s = (arm_s || silent_s) && bus.rx_busy;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stage_q <= `RDP_PTR_RST;
    end else if (i_sw_wr && (i_sw_addr == `RDP_H_STAGE)) begin
      stage_q <= {i_sw_wdata[`RDP_DW-1:2], 2'b00};
    end
  end

  // Sticky refusal flag; a new refusal wins over a clear in the same cycle
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      err_q <= 1'b0;
    end else if (refuse_s) begin
      err_q <= 1'b1;
    end else if (i_sw_wr && (i_sw_addr == `RDP_H_STAT) && i_sw_wdata[`RDP_HS_ERR]) begin
      err_q <= 1'b0;
    end
  end

  // ****************************************
  // Command sequencer
  // ****************************************
  logic               reg_wr_q;
  logic               reg_rd_q;
  logic [`RDP_AW-1:0] reg_addr_q;
  logic [`RDP_DW-1:0] reg_wdata_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q     <= RDP_H_IDLE;
      reg_wr_q    <= 1'b0;
      reg_rd_q    <= 1'b0;
      reg_addr_q  <= '0;
      reg_wdata_q <= '0;
      mirror_q    <= '0;
    end else begin
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      unique case (state_q)
        RDP_H_IDLE: begin
          if (stop_s) begin
            reg_wr_q    <= 1'b1;
            reg_addr_q  <= `RDP_REG_CMD;
            reg_wdata_q <= 32'h0000_0002;
          end else if ((arm_s || silent_s) && !refuse_s) begin
            // Pointer first, go strobe next cycle
            reg_wr_q    <= 1'b1;
            reg_addr_q  <= `RDP_REG_PTR;
            reg_wdata_q <= arm_s ? stage_q : 32'h0000_0000;
            state_q     <= RDP_H_GO;
          end else if (sample_s) begin
            reg_rd_q   <= 1'b1;
            reg_addr_q <= `RDP_REG_PTR;
            state_q    <= RDP_H_RDW;
          end
        end
        RDP_H_GO: begin
          reg_wr_q    <= 1'b1;
          reg_addr_q  <= `RDP_REG_CMD;
          reg_wdata_q <= 32'h0000_0001;
          state_q     <= RDP_H_IDLE;
        end
        RDP_H_RDW: begin
          state_q <= RDP_H_RDC;
        end
        RDP_H_RDC: begin
          mirror_q <= bus.reg_rdata;
          state_q  <= RDP_H_IDLE;
        end
      endcase
    end
  end

  assign bus.reg_wr    = reg_wr_q;
  assign bus.reg_rd    = reg_rd_q;
  assign bus.reg_addr  = reg_addr_q;
  assign bus.reg_wdata = reg_wdata_q;

  // ****************************************
  // Memory forwarding, one register each way
  // ****************************************
  logic               mreq_q;
  logic [`RDP_DW-1:0] maddr_q;
  logic               mack_q;
  logic [`RDP_DW-1:0] mdata_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mreq_q  <= 1'b0;
      maddr_q <= '0;
      mack_q  <= 1'b0;
      mdata_q <= '0;
    end else begin
      mreq_q <= bus.mem_req;
      mack_q <= i_mem_ack;
      if (bus.mem_req) begin
        maddr_q <= bus.mem_addr;
      end
      if (i_mem_ack) begin
        mdata_q <= i_mem_rdata;
      end
    end
  end

  assign o_mem_req     = mreq_q;
  assign o_mem_addr    = maddr_q;
  assign bus.mem_ack   = mack_q;
  assign bus.mem_rdata = mdata_q;

  // ****************************************
  // Software read
  // ****************************************
  logic [`RDP_DW-1:0] sw_rdata_q;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sw_rdata_q <= '0;
    end else if (i_sw_rd) begin
      unique case (i_sw_addr)
        `RDP_H_STAGE:  sw_rdata_q <= stage_q;
        `RDP_H_STAT:   sw_rdata_q <= {29'h0, err_q, bus.rx_busy, state_q != RDP_H_IDLE};
        `RDP_H_MIRROR: sw_rdata_q <= mirror_q;
        default:       sw_rdata_q <= '0;
      endcase
    end
  end

  assign o_sw_rdata = sw_rdata_q;

endmodule // rdp_host

// ### dv/rdp_properties.sv
// Link checks between the host end and the device end of the receive list pointer
`timescale 1ns/1ps
`include "rdp_consts.svh"
module rdp_properties (
  // Clock and reset
  input logic               i_mclk,
  input logic               i_rst_n,
  // Register link
  input logic               reg_wr,
  input logic               reg_rd,
  input logic [`RDP_AW-1:0] reg_addr,
  input logic [`RDP_DW-1:0] reg_wdata,
  input logic [`RDP_DW-1:0] reg_rdata,
  input logic               rx_busy,
  // Link fetch
  input logic               mem_req,
  input logic [`RDP_DW-1:0] mem_addr,
  input logic               mem_ack,
  input logic [`RDP_DW-1:0] mem_rdata
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  // ****************************************
  // Helpers
  // ****************************************
  logic        ptr_wr;
  logic        go_wr;
  logic        stop_wr;
  logic        null_lnk;
  logic [31:0] exp_q;
  logic        lend_q;
  logic        zero_q;
  logic        silent_q;
  assign ptr_wr   = reg_wr && reg_addr == `RDP_REG_PTR;
  assign stop_wr  = reg_wr && reg_addr == `RDP_REG_CMD && reg_wdata[`RDP_CMD_STOP];
  assign go_wr    = reg_wr && reg_addr == `RDP_REG_CMD && reg_wdata[`RDP_CMD_GO] && !stop_wr;
  assign null_lnk = mem_rdata[31:2] == 30'h0;

  // Pointer as last set; a null link leaves it where it was
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) exp_q <= `RDP_PTR_RST;
    else if (ptr_wr) exp_q <= {reg_wdata[31:2], 2'h0};
    else if (mem_ack && !null_lnk) exp_q <= {mem_rdata[31:2], 2'h0};
  end

  // Mode tracking; stop is the only way out of a list end besides a fetch
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lend_q   <= 1'h0;
      zero_q   <= 1'h1;
      silent_q <= 1'h0;
    end else begin
      if (mem_ack) lend_q <= null_lnk;
      else if (mem_req || stop_wr) lend_q <= 1'h0;
      if (ptr_wr) zero_q <= reg_wdata[31:2] == 30'h0;
      else if (mem_ack && !null_lnk) zero_q <= 1'h0;
      if (ptr_wr || stop_wr) silent_q <= 1'h0;
      else if (go_wr && zero_q && !lend_q && !rx_busy) silent_q <= 1'h1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  AST_PTR_RD_LOW: assert property (reg_rd && reg_addr == `RDP_REG_PTR |=> reg_rdata[1:0] == 2'h0)
    else $error("pointer read shows low bits set");
  AST_FETCH_LOW: assert property (mem_req |-> mem_addr[1:0] == 2'h0)
    else $error("fetch address not word aligned");
  AST_LINK_FOLLOW: assert property (mem_req && !lend_q |-> mem_addr == exp_q + `RDP_LINK_OFS)
    else $error("fetch does not follow the pointer");
  AST_NULL_HOLD: assert property (mem_req && lend_q |-> mem_addr == exp_q + `RDP_LINK_OFS)
    else $error("pointer moved past a null link");
  AST_NULL_STOP: assert property (mem_ack && null_lnk |-> ##[1:3] !rx_busy)
    else $error("still busy after a null link");
  AST_GO_REFETCH: assert property (go_wr && lend_q |-> ##[1:3] mem_req)
    else $error("go at list end did not refetch the link");
  AST_SILENT_IN: assert property (go_wr && zero_q && !lend_q && !rx_busy |=> !rx_busy [*4])
    else $error("zero pointer go started reception");
  AST_SILENT_QUIET: assert property (silent_q |-> !mem_req && !rx_busy)
    else $error("memory activity in silent mode");
  AST_RECOVER: assert property (go_wr && !zero_q && !lend_q && !rx_busy |-> ##[1:3] rx_busy)
    else $error("go with a valid pointer did not start reception");
endmodule // rdp_properties

// ### dv/rdp_tb_top.sv
// Self-checking bench joining host end and device end
`timescale 1ns/1ps
`include "rdp_consts.svh"
module rdp_tb_top;
  // ****************************************
  // Harness
  // ****************************************
  logic               i_mclk = 1'h0;
  logic               i_rst_n = 1'h0;
  logic [`RDP_AW-1:0] sw_addr = 8'h0;
  logic [`RDP_DW-1:0] sw_wdata = 32'h0;
  logic               sw_wr = 1'h0;
  logic               sw_rd = 1'h0;
  logic [`RDP_DW-1:0] sw_rdata;
  logic               mem_req;
  logic [`RDP_DW-1:0] mem_addr;
  logic               mem_ack = 1'h0;
  logic [`RDP_DW-1:0] mem_rdata = 32'h0;
  logic               frame_rdy = 1'h0;
  logic               dma_done = 1'h0;
  logic               dma_go;
  logic [`RDP_DW-1:0] dma_desc;
  logic               rx_active;
  logic               silent;
  logic               list_end;
  int                 mismatches = 0;
  int                 cmp_count = 0;
  int                 gos = 0;
  int                 moved = 0;
  int                 reqs = 0;
  int                 acked = 0;
  logic [31:0]        desc_at;
  logic [31:0]        req_at;
  typedef struct {logic [31:0] w; logic [31:0] p;} rdp_row_t;
  rdp_row_t rows [3] = '{'{32'h0000_1003, 32'h0000_1000}, '{32'hffff_fffd, 32'hffff_fffc},
                         '{32'h0000_0104, 32'h0000_0104}};

  always #5 i_mclk = ~i_mclk;

  rdp_if u_rdp_if ();
  rdp_host u_rdp_host (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sw_addr(sw_addr),
    .i_sw_wdata(sw_wdata), .i_sw_wr(sw_wr), .i_sw_rd(sw_rd), .o_sw_rdata(sw_rdata),
    .o_mem_req(mem_req), .o_mem_addr(mem_addr), .i_mem_ack(mem_ack),
    .i_mem_rdata(mem_rdata), .bus(u_rdp_if.host));
  rdp_dev u_rdp_dev (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .bus(u_rdp_if.dev),
    .i_frame_rdy(frame_rdy), .i_dma_done(dma_done), .o_dma_go(dma_go), .o_dma_desc(dma_desc),
    .o_rx_active(rx_active), .o_silent(silent), .o_list_end(list_end));
  rdp_properties u_rdp_properties (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .reg_wr(u_rdp_if.reg_wr), .reg_rd(u_rdp_if.reg_rd), .reg_addr(u_rdp_if.reg_addr),
    .reg_wdata(u_rdp_if.reg_wdata), .reg_rdata(u_rdp_if.reg_rdata),
    .rx_busy(u_rdp_if.rx_busy), .mem_req(u_rdp_if.mem_req), .mem_addr(u_rdp_if.mem_addr),
    .mem_ack(u_rdp_if.mem_ack), .mem_rdata(u_rdp_if.mem_rdata));

  // Pulses are counted here so that none is missed while a task waits elsewhere
  always @(posedge i_mclk) begin
    if (dma_go === 1'h1) begin
      gos++;
      desc_at = dma_desc;
    end
    if (mem_req === 1'h1) begin
      reqs++;
      req_at = mem_addr;
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'h1) begin
      mismatches++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish;
    $display("Compares %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'h1;
    @(posedge i_mclk);
    sw_wr <= 1'h0;
    repeat (6) @(posedge i_mclk);
  endtask
  // One-cycle read strobe; data is taken in the cycle after it
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    sw_addr <= a;
    sw_rd <= 1'h1;
    @(posedge i_mclk);
    sw_rd <= 1'h0;
    @(negedge i_mclk);
    d = sw_rdata;
  endtask
  // Device pointer, sampled into the mirror and read back
  task automatic peek(output logic [31:0] d);
    wr_reg(`RDP_H_CTRL, 32'h8);
    rd_reg(`RDP_H_MIRROR, d);
  endtask
  // Pointer is loaded before go, only while not receiving
  task automatic arm(input logic [31:0] p);
    wr_reg(`RDP_H_STAGE, p);
    wr_reg(`RDP_H_CTRL, 32'h1);
  endtask
  task automatic frame(input logic [31:0] desc);
    int n;
    n = 0;
    @(posedge i_mclk);
    frame_rdy <= 1'h1;
    while (gos == moved && n < 40) begin
      @(negedge i_mclk);
      n++;
    end
    moved = gos;
    chk(n < 40 && desc_at === desc, "descriptor of transfer");
    @(posedge i_mclk);
    frame_rdy <= 1'h0;
    repeat (3) @(posedge i_mclk);
    dma_done <= 1'h1;
    @(posedge i_mclk);
    dma_done <= 1'h0;
  endtask
  // Answer one link fetch; the data lines do not keep the link afterwards
  task automatic fetch(input logic [31:0] a, input logic [31:0] link);
    int n;
    n = 0;
    while (reqs == acked && n < 40) begin
      @(negedge i_mclk);
      n++;
    end
    acked = reqs;
    chk(n < 40 && req_at === a, "link fetch address");
    repeat (2) @(posedge i_mclk);
    mem_ack <= 1'h1;
    mem_rdata <= link;
    @(posedge i_mclk);
    mem_ack <= 1'h0;
    mem_rdata <= ~link;
    repeat (4) @(posedge i_mclk);
  endtask

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (5000) @(posedge i_mclk);
    mismatches++;
    tally_and_finish;
  end

  initial begin
    logic [31:0] d;
    int          g0;
    int          r0;
    repeat (5) @(posedge i_mclk);
    i_rst_n <= 1'h1;
    @(negedge i_mclk);
    chk(rx_active === 1'h0 && silent === 1'h0 && list_end === 1'h0, "outputs after reset");
    peek(d);
    chk(d === `RDP_PTR_RST, "pointer after reset");
    $display("test reset done");
    foreach (rows[i]) begin
      arm(rows[i].w);
      chk(rx_active === 1'h1, "receiving after go");
      peek(d);
      chk(d === rows[i].p, "low pointer bits");
      wr_reg(`RDP_H_CTRL, 32'h4);
      $display("test row %0d done", i);
    end
    arm(32'h0000_0100);
    // Arm while receiving must be refused and flagged, pointer untouched
    wr_reg(`RDP_H_STAGE, 32'h0000_0900);
    wr_reg(`RDP_H_CTRL, 32'h1);
    rd_reg(`RDP_H_STAT, d);
    chk(d === 32'h0000_0006, "refused arm flagged");
    wr_reg(`RDP_H_STAT, 32'h4);
    rd_reg(`RDP_H_STAT, d);
    chk(d === 32'h0000_0002, "refusal flag cleared");
    $display("test refusal done");
    frame(32'h0000_0100);
    fetch(32'h0000_0100, 32'h0000_0203);
    frame(32'h0000_0200);
    fetch(32'h0000_0200, 32'h0000_0000);
    chk(list_end === 1'h1 && rx_active === 1'h0, "waiting at list end");
    peek(d);
    chk(d === 32'h0000_0200, "pointer held at null link");
    arm(32'h0000_0200);
    fetch(32'h0000_0200, 32'h0000_0300);
    frame(32'h0000_0300);
    fetch(32'h0000_0300, 32'h0000_0000);
    wr_reg(`RDP_H_CTRL, 32'h4);
    $display("test list walk done");
    wr_reg(`RDP_H_CTRL, 32'h2);
    chk(silent === 1'h1 && rx_active === 1'h0, "silent mode entered");
    g0 = gos;
    r0 = reqs;
    @(posedge i_mclk);
    frame_rdy <= 1'h1;
    repeat (20) @(posedge i_mclk);
    chk(gos === g0 && reqs === r0, "nothing moved while silent");
    arm(32'h0000_0400);
    chk(silent === 1'h0, "silent mode left");
    frame(32'h0000_0400);
    fetch(32'h0000_0400, 32'h0000_0000);
    $display("test silent done");
    @(posedge i_mclk);
    i_rst_n <= 1'h0;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'h1;
    peek(d);
    chk(d === `RDP_PTR_RST && list_end === 1'h0, "state after second reset");
    $display("test second reset done");
    tally_and_finish;
  end
endmodule // rdp_tb_top
